//--- core/mcu_reset_controller.sv
`timescale 1ns/1ps
// Function
// - Clear pin low resets core, fetch from zero.
// - Low supply must persist over 1ms first.
// - Low supply reset only when configured enabled.
// - Running watchdog reset equals pin reset, sets timeout.
// - Sleep watchdog reset clears only counter, stack.
// - Power-on clears timeout and sleep flags.
// - Pin or supply reset keeps both flags.
// - Running watchdog reset keeps sleep flag.
// - Sleep watchdog reset sets both flags.
// - Power-on disables every interrupt source.
// - Power-on clears watchdog, which then counts.
// - Power-on stops every timer counter.
// - Power-on clears the timer prescaler.
// - Power-on makes every port pin input.
// - Power-on points stack pointer at top.
// - Port latches and directions set except sleep.
// - Pointer top bits read one after reset.
module mcu_reset_controller #(
  parameter int LOW_SUPPLY_FILTER_CYCLES = rstctl_pkg::LOW_SUPPLY_CYCLES,
  parameter int WDOG_BASE_BIT = rstctl_pkg::WDOG_BASE_BIT
) (
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic rstn,
  // Board reset sources and static option
  input wire logic ext_clear_pin_n,
  input wire logic low_supply_detector,
  input wire logic low_volt_reset_en,
  // Core state and requests
  input wire logic sleep_active,
  input wire logic halt_enter,
  input wire logic watchdog_kick,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // Reset strobes to the core
  output logic core_reset,
  output logic sleep_wake_reset,
  output logic prog_counter_low_clr,
  output logic stack_ptr_clr,
  output logic prescaler_clr,
  output logic [2:0] reset_cause,
  // Preset state
  output logic watchdog_timeout_flag,
  output logic sleep_entered_flag,
  output logic [7:0] watchdog_setup_reg,
  output logic [7:0] bank_select,
  output logic [3:0] nvm_control_reg,
  output logic [7:0] mem_pointer_zero,
  output logic [7:0] mem_pointer_one,
  output logic [7:0] intr_ctrl,
  output logic timer_run,
  output logic [rstctl_pkg::NUM_PORTS-1:0][7:0] port_latch,
  output logic [rstctl_pkg::NUM_PORTS-1:0][7:0] port_dir
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ---------------------------------------------------------------
  // Reset sources
  // ---------------------------------------------------------------
  logic por_done_q;
  logic low_fire;
  logic wdog_timeout;
  logic wdog_clear;

  low_supply_filter #(
    .CYCLES(LOW_SUPPLY_FILTER_CYCLES)
  ) u_low_supply_filter (
    .mclk(mclk),
    .rstn(rstn),
    .enable(low_volt_reset_en),
    .low_level(low_supply_detector),
    .fire(low_fire)
  );

  watchdog_counter_unit #(
    .BASE_BIT(WDOG_BASE_BIT)
  ) u_watchdog (
    .mclk(mclk),
    .rstn(rstn),
    .clear(wdog_clear),
    .period_sel(watchdog_setup_reg[rstctl_pkg::WDOG_SEL_W-1:0]),
    .timeout(wdog_timeout)
  );

  // ---------------------------------------------------------------
  // Cause encoding
  // ---------------------------------------------------------------
  rstctl_pkg::reset_cause_t cause_d;
  rstctl_pkg::reset_cause_t cause_q;
  rstctl_pkg::reset_cause_t last_cause_q;
  logic full_d;
  logic sleep_d;
  logic full_q;
  logic sleep_q;

  // Power-on outranks the pin, the pin outranks the supply monitor.
  assign cause_d = !por_done_q ? rstctl_pkg::cause_por :
                   !ext_clear_pin_n ? rstctl_pkg::cause_pin :
                   low_fire ? rstctl_pkg::cause_low_supply :
                   (wdog_timeout && sleep_active) ? rstctl_pkg::cause_wdog_sleep :
                   wdog_timeout ? rstctl_pkg::cause_wdog_run :
                   rstctl_pkg::cause_none;
  assign full_d = (cause_d != rstctl_pkg::cause_none) &&
                  (cause_d != rstctl_pkg::cause_wdog_sleep);
  assign sleep_d = (cause_d == rstctl_pkg::cause_wdog_sleep);
  assign full_q = (cause_q != rstctl_pkg::cause_none) &&
                  (cause_q != rstctl_pkg::cause_wdog_sleep);
  assign sleep_q = (cause_q == rstctl_pkg::cause_wdog_sleep);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      por_done_q <= 1'b0;
      cause_q <= rstctl_pkg::cause_por;
      last_cause_q <= rstctl_pkg::cause_por;
    end else begin
      por_done_q <= 1'b1;
      cause_q <= cause_d;
      if (cause_d != rstctl_pkg::cause_none) begin
        last_cause_q <= cause_d;
      end
    end
  end

  assign core_reset = full_q;
  assign sleep_wake_reset = sleep_q;
  assign prog_counter_low_clr = full_q || sleep_q;
  assign stack_ptr_clr = full_q || sleep_q;
  assign prescaler_clr = full_q;
  assign reset_cause = cause_q;
  assign wdog_clear = full_q || watchdog_kick;

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  logic to_q;
  logic to_d;
  logic pdf_q;
  logic pdf_d;

  // Reset events beat the software set and clear in the same cycle.
  always_comb begin
    to_d = to_q;
    pdf_d = pdf_q;
    unique case (cause_d)
      rstctl_pkg::cause_por: begin
        to_d = 1'b0;
        pdf_d = 1'b0;
      end
      rstctl_pkg::cause_pin, rstctl_pkg::cause_low_supply: begin
        to_d = to_q;
        pdf_d = pdf_q;
      end
      rstctl_pkg::cause_wdog_run: begin
        to_d = 1'b1;
      end
      rstctl_pkg::cause_wdog_sleep: begin
        to_d = 1'b1;
        pdf_d = 1'b1;
      end
      rstctl_pkg::cause_none: begin
        if (watchdog_kick) begin
          to_d = 1'b0;
          pdf_d = 1'b0;
        end else if (halt_enter) begin
          to_d = 1'b0;
          pdf_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      to_q <= 1'b0;
      pdf_q <= 1'b0;
    end else begin
      to_q <= to_d;
      pdf_q <= pdf_d;
    end
  end

  assign watchdog_timeout_flag = to_q;
  assign sleep_entered_flag = pdf_q;

  // ---------------------------------------------------------------
  // Preset registers
  // ---------------------------------------------------------------
  logic wr_wdog;
  logic wr_bank;
  logic wr_nvm;
  logic wr_mp0;
  logic wr_mp1;
  logic wr_intr;
  logic wr_timer;
  logic [7:0] wdog_setup_q;
  logic [7:0] bank_q;
  logic [3:0] nvm_q;
  logic [6:0] mp0_q;
  logic [6:0] mp1_q;
  logic [7:0] intr_q;
  logic [7:0] timer_q;

  assign wr_wdog = reg_we && (reg_addr == rstctl_pkg::ADDR_WDOG_SETUP);
  assign wr_bank = reg_we && (reg_addr == rstctl_pkg::ADDR_BANK);
  assign wr_nvm = reg_we && (reg_addr == rstctl_pkg::ADDR_NVM_CTRL);
  assign wr_mp0 = reg_we && (reg_addr == rstctl_pkg::ADDR_MEM_PTR0);
  assign wr_mp1 = reg_we && (reg_addr == rstctl_pkg::ADDR_MEM_PTR1);
  assign wr_intr = reg_we && (reg_addr == rstctl_pkg::ADDR_INTR_CTRL);
  assign wr_timer = reg_we && (reg_addr == rstctl_pkg::ADDR_TIMER_CTRL);

  // A preset in the same cycle as a write wins; a sleep wake keeps all.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdog_setup_q <= rstctl_pkg::WDOG_SETUP_RST;
      bank_q <= rstctl_pkg::BANK_RST;
      nvm_q <= rstctl_pkg::NVM_CTRL_RST;
      intr_q <= rstctl_pkg::INTR_CTRL_RST;
      timer_q <= rstctl_pkg::TIMER_CTRL_RST;
    end else if (full_d) begin
      wdog_setup_q <= rstctl_pkg::WDOG_SETUP_RST;
      bank_q <= rstctl_pkg::BANK_RST;
      nvm_q <= rstctl_pkg::NVM_CTRL_RST;
      intr_q <= rstctl_pkg::INTR_CTRL_RST;
      timer_q <= rstctl_pkg::TIMER_CTRL_RST;
    end else if (!sleep_d) begin
      if (wr_wdog) wdog_setup_q <= reg_wdata;
      if (wr_bank) bank_q <= reg_wdata;
      if (wr_nvm) nvm_q <= reg_wdata[3:0];
      if (wr_intr) intr_q <= reg_wdata;
      if (wr_timer) timer_q <= reg_wdata;
    end
  end

  // Pointer low bits survive every reset after power-up.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mp0_q <= rstctl_pkg::MEM_PTR_LOW_RST;
      mp1_q <= rstctl_pkg::MEM_PTR_LOW_RST;
    end else if (cause_d == rstctl_pkg::cause_none) begin
      if (wr_mp0) mp0_q <= reg_wdata[6:0];
      if (wr_mp1) mp1_q <= reg_wdata[6:0];
    end
  end

  assign watchdog_setup_reg = wdog_setup_q;
  assign bank_select = bank_q;
  assign nvm_control_reg = nvm_q;
  assign mem_pointer_zero = {1'b1, mp0_q};
  assign mem_pointer_one = {1'b1, mp1_q};
  assign intr_ctrl = intr_q;
  assign timer_run = timer_q[rstctl_pkg::TIMER_RUN_BIT];

  // ---------------------------------------------------------------
  // Ports
  // ---------------------------------------------------------------
  logic [rstctl_pkg::NUM_PORTS-1:0][7:0] port_rd;

  for (genvar i = 0; i < rstctl_pkg::NUM_PORTS; i++) begin : g_port
    localparam logic [3:0] LATCH_ADDR = 4'(rstctl_pkg::ADDR_PORT_BASE + 2 * i);
    localparam logic [3:0] DIR_ADDR = 4'(rstctl_pkg::ADDR_PORT_BASE + 2 * i + 1);
    logic [7:0] latch_q;
    logic [7:0] dir_q;
    logic latch_hit;
    logic dir_hit;

    assign latch_hit = (reg_addr == LATCH_ADDR);
    assign dir_hit = (reg_addr == DIR_ADDR);

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        latch_q <= rstctl_pkg::PORT_RST;
        dir_q <= rstctl_pkg::PORT_RST;
      end else if (full_d) begin
        latch_q <= rstctl_pkg::PORT_RST;
        dir_q <= rstctl_pkg::PORT_RST;
      end else if (!sleep_d) begin
        if (reg_we && latch_hit) latch_q <= reg_wdata;
        if (reg_we && dir_hit) dir_q <= reg_wdata;
      end
    end

    assign port_latch[i] = latch_q;
    assign port_dir[i] = dir_q;
    assign port_rd[i] = ({8{latch_hit}} & latch_q) | ({8{dir_hit}} & dir_q);

    property p_port_preset;
      full_q |-> dir_q == rstctl_pkg::PORT_RST && latch_q == rstctl_pkg::PORT_RST;
    endproperty
    a_port_preset: assert property (p_port_preset)
      else $error("port not set to input after reset");
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  logic [7:0] status_val;
  logic [7:0] port_rd_any;
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;

  always_comb begin
    port_rd_any = 8'h00;
    for (int k = 0; k < rstctl_pkg::NUM_PORTS; k++) begin
      port_rd_any = port_rd_any | port_rd[k];
    end
  end

  always_comb begin
    status_val = 8'h00;
    status_val[rstctl_pkg::ST_TIMEOUT_BIT] = to_q;
    status_val[rstctl_pkg::ST_SLEEP_BIT] = pdf_q;
  end

  assign rd_mux =
    (reg_addr == rstctl_pkg::ADDR_STATUS) ? status_val :
    (reg_addr == rstctl_pkg::ADDR_WDOG_SETUP) ? wdog_setup_q :
    (reg_addr == rstctl_pkg::ADDR_BANK) ? bank_q :
    (reg_addr == rstctl_pkg::ADDR_NVM_CTRL) ? {4'h0, nvm_q} :
    (reg_addr == rstctl_pkg::ADDR_MEM_PTR0) ? mem_pointer_zero :
    (reg_addr == rstctl_pkg::ADDR_MEM_PTR1) ? mem_pointer_one :
    (reg_addr == rstctl_pkg::ADDR_INTR_CTRL) ? intr_q :
    (reg_addr == rstctl_pkg::ADDR_TIMER_CTRL) ? timer_q :
    (reg_addr == rstctl_pkg::ADDR_CAUSE) ? {5'h00, last_cause_q} :
    port_rd_any;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_re ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_wdog_seen;
    wdog_timeout && por_done_q && ext_clear_pin_n && !low_fire;
  endsequence

  sequence s_wdog_applied;
    cause_q == rstctl_pkg::cause_wdog_run || cause_q == rstctl_pkg::cause_wdog_sleep;
  endsequence

  property p_pin_reset;
    por_done_q && !ext_clear_pin_n |=> core_reset && prog_counter_low_clr &&
      reset_cause == rstctl_pkg::cause_pin;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("clear pin did not reset the core");

  property p_low_supply_cause;
    reset_cause == rstctl_pkg::cause_low_supply |->
      $past(low_volt_reset_en) && $past(low_supply_detector, 2);
  endproperty
  a_low_supply_cause: assert property (p_low_supply_cause)
    else $error("low supply reset without enabled option and low supply");

  property p_wdog_run;
    reset_cause == rstctl_pkg::cause_wdog_run |-> watchdog_timeout_flag &&
      sleep_entered_flag == $past(sleep_entered_flag) && core_reset;
  endproperty
  a_wdog_run: assert property (p_wdog_run)
    else $error("running watchdog reset flags wrong");

  property p_wdog_sleep;
    sleep_wake_reset |-> watchdog_timeout_flag && sleep_entered_flag && !core_reset &&
      bank_select == $past(bank_select) && watchdog_setup_reg == $past(watchdog_setup_reg) &&
      nvm_control_reg == $past(nvm_control_reg) && prog_counter_low_clr;
  endproperty
  a_wdog_sleep: assert property (p_wdog_sleep)
    else $error("sleep watchdog reset changed kept state");

  property p_por_flags;
    reset_cause == rstctl_pkg::cause_por |-> !watchdog_timeout_flag && !sleep_entered_flag;
  endproperty
  a_por_flags: assert property (p_por_flags)
    else $error("power-on reset left a flag set");

  property p_pin_keeps_flags;
    (reset_cause == rstctl_pkg::cause_pin || reset_cause == rstctl_pkg::cause_low_supply) |->
      $stable(watchdog_timeout_flag) && $stable(sleep_entered_flag);
  endproperty
  a_pin_keeps_flags: assert property (p_pin_keeps_flags)
    else $error("pin or supply reset changed a flag");

  property p_full_presets;
    core_reset |-> watchdog_setup_reg == rstctl_pkg::WDOG_SETUP_RST &&
      bank_select == rstctl_pkg::BANK_RST && nvm_control_reg == rstctl_pkg::NVM_CTRL_RST &&
      intr_ctrl == rstctl_pkg::INTR_CTRL_RST && !timer_run && prescaler_clr && stack_ptr_clr;
  endproperty
  a_full_presets: assert property (p_full_presets)
    else $error("register not preset by reset");

  property p_ptr_msb;
    mem_pointer_zero[rstctl_pkg::MEM_PTR_MSB] && mem_pointer_one[rstctl_pkg::MEM_PTR_MSB] &&
      (reset_cause inside {rstctl_pkg::cause_none, rstctl_pkg::cause_por} ||
      (mem_pointer_zero == $past(mem_pointer_zero) &&
      mem_pointer_one == $past(mem_pointer_one)));
  endproperty
  a_ptr_msb: assert property (p_ptr_msb)
    else $error("pointer top bit not one");

  property p_wdog_to_cause;
    s_wdog_seen |=> s_wdog_applied ##1 (reset_cause != rstctl_pkg::cause_wdog_run ||
      $past(wdog_timeout));
  endproperty
  a_wdog_to_cause: assert property (p_wdog_to_cause)
    else $error("watchdog time-out not encoded as cause");

endmodule : mcu_reset_controller

//--- core/rstctl_pkg.sv
package rstctl_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int LOW_SUPPLY_MIN_US = 1000;
  localparam int LOW_SUPPLY_CYCLES = LOW_SUPPLY_MIN_US * CLK_MHZ;
  localparam int LOW_SUPPLY_CNT_W = 17;
  localparam int WDOG_CNT_W = 20;
  localparam int WDOG_BASE_BIT = 12;
  localparam int WDOG_SEL_W = 3;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam int NUM_PORTS = 2;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_WDOG_SETUP = 4'h1;
  localparam logic [3:0] ADDR_BANK = 4'h2;
  localparam logic [3:0] ADDR_NVM_CTRL = 4'h3;
  localparam logic [3:0] ADDR_MEM_PTR0 = 4'h4;
  localparam logic [3:0] ADDR_MEM_PTR1 = 4'h5;
  localparam logic [3:0] ADDR_PORT_BASE = 4'h6;
  localparam logic [3:0] ADDR_INTR_CTRL = 4'ha;
  localparam logic [3:0] ADDR_TIMER_CTRL = 4'hb;
  localparam logic [3:0] ADDR_CAUSE = 4'hc;
  localparam int ST_TIMEOUT_BIT = 4;
  localparam int ST_SLEEP_BIT = 3;
  localparam int TIMER_RUN_BIT = 4;
  localparam int MEM_PTR_MSB = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] WDOG_SETUP_RST = 8'h07;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [3:0] NVM_CTRL_RST = 4'h8;
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] INTR_CTRL_RST = 8'h00;
  localparam logic [7:0] TIMER_CTRL_RST = 8'h08;
  localparam logic [6:0] MEM_PTR_LOW_RST = 7'h00;

  typedef enum logic [2:0] {
    cause_none,
    cause_por,
    cause_pin,
    cause_low_supply,
    cause_wdog_run,
    cause_wdog_sleep
  } reset_cause_t;

endpackage : rstctl_pkg

//--- core/low_supply_filter.sv
`timescale 1ns/1ps
module low_supply_filter #(
  parameter int CYCLES = rstctl_pkg::LOW_SUPPLY_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Supply monitor
  input wire logic enable,
  input wire logic low_level,
  output logic fire
);

  localparam logic [rstctl_pkg::LOW_SUPPLY_CNT_W-1:0] LIMIT =
    rstctl_pkg::LOW_SUPPLY_CNT_W'(CYCLES);

  logic [rstctl_pkg::LOW_SUPPLY_CNT_W-1:0] cnt_q;
  logic [rstctl_pkg::LOW_SUPPLY_CNT_W-1:0] cnt_d;
  logic at_limit;
  logic fire_q;

  // The counter restarts on any high sample, so short dips never fire.
  assign at_limit = (cnt_q == LIMIT);
  assign cnt_d = (!enable || !low_level) ? '0 : (at_limit ? cnt_q : cnt_q + 1'b1);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      fire_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      fire_q <= enable && low_level && at_limit;
    end
  end

  assign fire = fire_q;

  property p_filter_needs_low;
    @(posedge mclk) disable iff (!rstn)
    fire |-> $past(low_level) && $past(cnt_q) == LIMIT;
  endproperty
  a_filter_needs_low: assert property (p_filter_needs_low)
    else $error("low supply reset fired before the filter time");

endmodule : low_supply_filter

//--- core/watchdog_counter_unit.sv
`timescale 1ns/1ps
module watchdog_counter_unit #(
  parameter int BASE_BIT = rstctl_pkg::WDOG_BASE_BIT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic clear,
  input wire logic [rstctl_pkg::WDOG_SEL_W-1:0] period_sel,
  // Event
  output logic timeout
);

  logic [rstctl_pkg::WDOG_CNT_W-1:0] watchdog_counter_q;
  logic [rstctl_pkg::WDOG_CNT_W-1:0] watchdog_counter_d;
  logic [4:0] tap_idx;
  logic tap_hit;
  logic timeout_q;

  // The period doubles with each step of the setup value.
  assign tap_idx = 5'(BASE_BIT) + {2'b00, period_sel};
  assign tap_hit = watchdog_counter_q[tap_idx];
  assign watchdog_counter_d = (clear || tap_hit) ? '0 : watchdog_counter_q + 1'b1;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      watchdog_counter_q <= '0;
      timeout_q <= 1'b0;
    end else begin
      watchdog_counter_q <= watchdog_counter_d;
      timeout_q <= tap_hit;
    end
  end

  assign timeout = timeout_q;

endmodule : watchdog_counter_unit

//--- tb/core_side_model.sv
`timescale 1ns/1ps
module core_side_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Sleep request and reset strobes
  input wire logic sleep_req,
  input wire logic core_reset,
  input wire logic sleep_wake_reset,
  // Core state
  output logic sleep_active,
  output logic halt_enter
);
  // The core enters power-down on request and any reset strobe wakes it.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sleep_active <= 1'b0;
      halt_enter <= 1'b0;
    end else begin
      halt_enter <= sleep_req && !sleep_active && !halt_enter;
      if (core_reset || sleep_wake_reset) begin
        sleep_active <= 1'b0;
      end else if (halt_enter) begin
        sleep_active <= 1'b1;
      end
    end
  end
endmodule : core_side_model

//--- tb/tb_mcu_reset_controller.sv
`timescale 1ns/1ps
module tb_mcu_reset_controller;
  localparam int FILT = 20;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ext_clear_pin_n = 1'b1;
  logic low_supply_detector = 1'b0;
  logic low_volt_reset_en = 1'b0;
  logic sleep_req = 1'b0;
  logic watchdog_kick = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic sleep_active, halt_enter, core_reset, sleep_wake_reset, timer_run;
  logic prog_counter_low_clr, stack_ptr_clr, prescaler_clr;
  logic watchdog_timeout_flag, sleep_entered_flag;
  logic [2:0] reset_cause;
  logic [3:0] nvm_control_reg;
  logic [7:0] reg_rdata, watchdog_setup_reg, bank_select, mem_pointer_zero;
  logic [7:0] mem_pointer_one, intr_ctrl;
  logic [rstctl_pkg::NUM_PORTS-1:0][7:0] port_latch, port_dir;
  int num_errors = 0;
  int n_compared = 0;

  always #4 mclk = ~mclk;

  mcu_reset_controller #(
    .LOW_SUPPLY_FILTER_CYCLES(FILT),
    .WDOG_BASE_BIT(2)
  ) i_mcu_reset_controller (
    .mclk, .rstn, .ext_clear_pin_n, .low_supply_detector, .low_volt_reset_en,
    .sleep_active, .halt_enter, .watchdog_kick, .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .core_reset, .sleep_wake_reset, .prog_counter_low_clr,
    .stack_ptr_clr, .prescaler_clr, .reset_cause, .watchdog_timeout_flag,
    .sleep_entered_flag, .watchdog_setup_reg, .bank_select, .nvm_control_reg,
    .mem_pointer_zero, .mem_pointer_one, .intr_ctrl, .timer_run, .port_latch, .port_dir
  );

  core_side_model i_core_side_model (
    .mclk, .rstn, .sleep_req, .core_reset, .sleep_wake_reset, .sleep_active, .halt_enter
  );

  // ---------------------------------------------------------------
  // Access and comparison tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [7:0] seen_v, input logic [7:0] exp_v);
    n_compared++;
    if (seen_v !== exp_v) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1;
    chk(what, reg_rdata, e);
  endtask : rd

  // Waits for the core or the sleep wake strobe under a bound.
  task automatic wait_sig(input bit wake, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge mclk);
      #1;
      if ((wake ? sleep_wake_reset : core_reset) === 1'b1) return;
    end
    num_errors++;
    $display("mismatch wait expected 1 seen 0");
    wrap_up();
  endtask : wait_sig

  task automatic presets();
    chk("setup", watchdog_setup_reg, 8'h07);
    chk("bank", bank_select, 8'h00);
    chk("nvm", {4'h0, nvm_control_reg}, 8'h08);
    chk("intr", intr_ctrl, 8'h00);
    chk("timer", {7'h0, timer_run}, 8'h00);
    chk("ptrs", {6'h0, mem_pointer_zero[7], mem_pointer_one[7]}, 8'h03);
    for (int p = 0; p < rstctl_pkg::NUM_PORTS; p++) begin
      chk("latch", port_latch[p], 8'hff);
      chk("dir", port_dir[p], 8'hff);
    end
  endtask : presets

  task automatic supply(input int n, input logic e);
    logic seen;
    seen = 1'b0;
    wr(4'h2, 8'h55);
    low_supply_detector <= 1'b1;
    for (int i = 0; i < n + 4; i++) begin
      @(posedge mclk);
      if (i == n - 1) low_supply_detector <= 1'b0;
      #1;
      seen |= core_reset;
    end
    chk("supply", {7'h0, seen}, {7'h0, e});
  endtask : supply

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    presets();
    chk("flags", {watchdog_timeout_flag, sleep_entered_flag}, 8'h00);
    rd(4'h0, 8'h00, "status");
    wr(4'h4, 8'h2a);
    rd(4'h4, 8'haa, "ptr0");
    wr(4'h2, 8'h55);
    rd(4'h2, 8'h55, "bank rw");
    wait_sig(0, 600);
    chk("cause run", {5'h0, reset_cause}, 8'h04);
    chk("flags run", {watchdog_timeout_flag, sleep_entered_flag}, 8'h02);
    repeat (2) @(posedge mclk);
    #1;
    presets();
    wr(4'h2, 8'h55);
    wr(4'h6, 8'h00);
    ext_clear_pin_n <= 1'b0;
    wait_sig(0, 4);
    chk("cause pin", {5'h0, reset_cause}, 8'h02);
    chk("pc clr", {7'h0, prog_counter_low_clr}, 8'h01);
    chk("presc clr", {7'h0, prescaler_clr}, 8'h01);
    @(posedge mclk);
    ext_clear_pin_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    presets();
    chk("flag pin", {7'h0, watchdog_timeout_flag}, 8'h01);
    supply(40, 1'b0);
    @(posedge mclk);
    low_volt_reset_en <= 1'b1;
    supply(FILT, 1'b0);
    supply(FILT + 1, 1'b1);
    presets();
    chk("flag supply", {7'h0, watchdog_timeout_flag}, 8'h01);
    @(posedge mclk);
    watchdog_kick <= 1'b1;
    wr(4'h1, 8'h06);
    watchdog_kick <= 1'b0;
    wr(4'h2, 8'h55);
    wr(4'h6, 8'h00);
    sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("flags halt", {watchdog_timeout_flag, sleep_entered_flag}, 8'h01);
    wait_sig(1, 600);
    chk("cause sleep", {5'h0, reset_cause}, 8'h05);
    chk("core held", {7'h0, core_reset}, 8'h00);
    chk("sp clr", {6'h0, stack_ptr_clr, prog_counter_low_clr}, 8'h03);
    chk("flags sleep", {watchdog_timeout_flag, sleep_entered_flag}, 8'h03);
    repeat (2) @(posedge mclk);
    #1;
    chk("setup kept", watchdog_setup_reg, 8'h06);
    chk("bank kept", bank_select, 8'h55);
    chk("latch kept", port_latch[0], 8'h00);
    chk("ptr kept", mem_pointer_zero, 8'haa);
    rd(4'hc, 8'h05, "last cause");
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    presets();
    chk("flags por", {watchdog_timeout_flag, sleep_entered_flag}, 8'h00);
    wrap_up();
  end
endmodule : tb_mcu_reset_controller
